// ==== design/mfd_pkg.sv ====
// Shared constants and helpers for the freefall/motion debounce block.
package mfd_pkg;

  // Register offsets on the device register port.
  localparam logic [7:0] MFD_CFG_ADDR   = 8'h15;
  localparam logic [7:0] MFD_SRC_ADDR   = 8'h16;
  localparam logic [7:0] MFD_THS_ADDR   = 8'h17;
  localparam logic [7:0] MFD_COUNT_ADDR = 8'h18;

  // Configuration register fields.
  localparam int MFD_CFG_LATCH_BIT   = 7;
  localparam int MFD_CFG_COMBINE_BIT = 6;
  localparam int MFD_CFG_ZEN_BIT     = 5;
  localparam int MFD_CFG_YEN_BIT     = 4;
  localparam int MFD_CFG_XEN_BIT     = 3;

  // Source register fields.
  localparam int MFD_SRC_EA_BIT   = 7;
  localparam int MFD_SRC_ZFLG_BIT = 5;
  localparam int MFD_SRC_ZPOL_BIT = 4;
  localparam int MFD_SRC_YFLG_BIT = 3;
  localparam int MFD_SRC_YPOL_BIT = 2;
  localparam int MFD_SRC_XFLG_BIT = 1;
  localparam int MFD_SRC_XPOL_BIT = 0;

  // Threshold register fields.
  localparam int MFD_THS_MODE_BIT = 7;
  localparam int MFD_THS_MSB      = 6;

  // Reset values.
  localparam logic [4:0] MFD_CFG_RESET   = 5'h00;
  localparam logic       MFD_MODE_RESET  = 1'b0;
  localparam logic [6:0] MFD_THS_RESET   = 7'h00;
  localparam logic [7:0] MFD_COUNT_RESET = 8'h00;

  // With low noise on, 4 g at 0.063 g per count is the highest threshold.
  localparam logic [6:0] MFD_LOW_NOISE_THS_MAX = 7'h3F;

  // Timing: the shortest debounce step is 1.25 ms at a 50 ns clock.
  localparam int MFD_CLK_PERIOD_NS = 50;
  localparam int MFD_STEP_BASE_NS  = 1250000;
  localparam int MFD_STEP_BASE_CYCLES = MFD_STEP_BASE_NS / MFD_CLK_PERIOD_NS;

  // Data rate codes, fastest first.
  typedef enum logic [2:0] {
    MFD_ODR_800, MFD_ODR_400, MFD_ODR_200, MFD_ODR_100,
    MFD_ODR_50, MFD_ODR_12P5, MFD_ODR_6P25, MFD_ODR_1P56
  } mfd_odr_t;

  // Oversampling modes.
  typedef enum logic [1:0] {
    MFD_OS_NORMAL, MFD_OS_LOW_NOISE_LOW_POWER,
    MFD_OS_HIGH_RESOLUTION, MFD_OS_LOW_POWER
  } mfd_os_t;

  // Step length as a multiple of the 1.25 ms base step.
  function automatic logic [7:0] mfd_step_mult(input mfd_odr_t odr,
                                               input mfd_os_t  os);
    logic [7:0] m;
    m = 8'h01;
    unique case (odr)
      MFD_ODR_800:  m = 8'h01;
      MFD_ODR_400:  m = 8'h02;
      MFD_ODR_200:  m = 8'h04;
      MFD_ODR_100:  m = 8'h08;
      MFD_ODR_50:   m = 8'h10;
      MFD_ODR_12P5: m = 8'h40;
      MFD_ODR_6P25: m = 8'h80;
      MFD_ODR_1P56: m = 8'h80;
    endcase
    unique case (os)
      MFD_OS_HIGH_RESOLUTION: m = (m > 8'h02) ? 8'h02 : m;
      MFD_OS_NORMAL:          m = (m > 8'h10) ? 8'h10 : m;
      MFD_OS_LOW_NOISE_LOW_POWER: m = (m > 8'h40) ? 8'h40 : m;
      MFD_OS_LOW_POWER:       m = m;
    endcase
    return m;
  endfunction

endpackage

// ==== design/mfd_step_gen.sv ====
// Sample step pulse generator following data rate and oversampling mode.
`timescale 1ns/1ns
`default_nettype none
module mfd_step_gen
  import mfd_pkg::*;
#(
  parameter int BASE_CYCLES = MFD_STEP_BASE_CYCLES
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic [2:0] odr_in,
  input  wire logic [1:0] os_mode_in,
  output logic            tick_out
);

  logic [31:0] base_cnt_reg;
  logic [7:0]  mult_cnt_reg;
  logic [7:0]  mult;
  logic        base_done;

  assign mult      = mfd_step_mult(mfd_odr_t'(odr_in), mfd_os_t'(os_mode_in));
  assign base_done = (base_cnt_reg >= 32'(BASE_CYCLES - 1));

  // Base counter marks each 1.25 ms slot.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || base_done) begin
      base_cnt_reg <= 32'h0000_0000;
    end else begin
      base_cnt_reg <= base_cnt_reg + 32'h0000_0001;
    end
  end

  // A rate change takes effect at the next slot boundary, never mid-slot.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mult_cnt_reg <= 8'h00;
      tick_out     <= 1'b0;
    end else if (base_done) begin
      if (mult_cnt_reg + 8'h01 >= mult) begin
        mult_cnt_reg <= 8'h00;
        tick_out     <= 1'b1;
      end else begin
        mult_cnt_reg <= mult_cnt_reg + 8'h01;
        tick_out     <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== design/mfd_axis.sv ====
// One axis: magnitude compare and motion and polarity flags.
`timescale 1ns/1ns
`default_nettype none
module mfd_axis
  import mfd_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic              tick_in,
  input  wire logic [DATA_W-1:0] accel_in,
  input  wire logic [6:0]        threshold_in,
  input  wire logic              enable_in,
  input  wire logic              freeze_in,
  input  wire logic              clear_in,
  output logic                   high_out,
  output logic                   low_out,
  output logic                   flag_out,
  output logic                   pol_out
);

  logic [DATA_W-1:0] mag;
  logic              neg;

  assign neg      = accel_in[DATA_W-1];
  assign mag      = neg ? (~accel_in + 1'b1) : accel_in;
  assign high_out = mag > DATA_W'(threshold_in);
  assign low_out  = !high_out;

  // Flags follow the raw condition each step unless frozen, with no debounce.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      flag_out <= 1'b0;
      pol_out  <= 1'b0;
    end else if (!enable_in) begin
      flag_out <= 1'b0;
      pol_out  <= 1'b0;
    end else if (tick_in && !freeze_in) begin
      flag_out <= high_out;
      if (high_out) begin
        pol_out <= neg;
      end
    end else if (clear_in) begin
      flag_out <= 1'b0;
      pol_out  <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== design/mfd_core.sv ====
// Freefall/motion event detection with debounce and register port.
//
// How it works
// - Event-active reads 1 when enabled axis events are asserted, else 0.
// - An axis flag and polarity read zero while that axis is disabled.
// - Polarity flag is 0 for a positive-g event, 1 for negative-g.
// - Event-active sets when the selected axis combination holds after debounce.
// - Event-active gated by interrupt enable and pin route drives interrupts.
// - An axis motion condition is magnitude strictly above threshold.
// - Freefall needs every enabled axis magnitude at or below threshold.
// - Threshold register: mode select bit 7, threshold bits 6..0, reset 0.
// - Threshold counts 0.063 g each, reaching 8 g in any range.
// - With low noise set, the usable threshold stops at 4 g.
// - Mode select 1 clears the debounce counter when condition is false.
// - Mode select 0 decrements the counter to zero when condition false.
// - Debounce count register is 8-bit read/write, reset zero.
// - Counter reaching the programmed count sets the event flag.
// - Counter saturates at the programmed count value.
// - Step is 1.25 ms at 800 Hz, scaling with data rate.
// - Slow rates use oversampling-dependent steps of 2.5 to 160 ms.
// - Combine select 0 is AND freefall, 1 is OR motion, reset 0.
// - Latched mode freezes flags once event-active sets; source read clears event-active and, unless a step lands in that cycle, the flags.
// - Latched source read also clears the counter, restarting the delay.
`timescale 1ns/1ns
`default_nettype none
module mfd_core
  import mfd_pkg::*;
#(
  parameter int DATA_W      = 8,
  parameter int STEP_CYCLES = MFD_STEP_BASE_CYCLES
) (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  input  wire logic [7:0]        reg_wdata_in,
  output logic      [7:0]        reg_rdata_out,
  input  wire logic [DATA_W-1:0] accel_x_in,
  input  wire logic [DATA_W-1:0] accel_y_in,
  input  wire logic [DATA_W-1:0] accel_z_in,
  input  wire logic [2:0]        odr_in,
  input  wire logic [1:0]        os_mode_in,
  input  wire logic              low_noise_in,
  input  wire logic              motion_irq_enable_in,
  input  wire logic              motion_irq_pin_route_in,
  output logic                   int1_out,
  output logic                   int2_out,
  output logic                   event_active_out
);

  // Configuration and threshold registers.
  logic       event_latch_enable_reg;
  logic       axis_combine_select_reg;
  logic [2:0] axis_enable_reg;
  logic       debounce_mode_select_reg;
  logic [6:0] threshold_value_reg;
  logic [7:0] motion_debounce_count_reg;

  // Event state.
  logic       event_active_reg;
  logic       event_active_next;
  logic [7:0] debounce_cnt_reg;
  logic [7:0] debounce_cnt_next;

  logic       tick;
  logic       src_read;
  logic       read_clear;
  logic       freeze;
  logic [6:0] ths_eff;
  logic [2:0] high;
  logic [2:0] low;
  logic [2:0] flag;
  logic [2:0] pol;
  logic       any_en;
  logic       condition;
  logic [7:0] cnt_base;
  logic       ea_base;
  logic [7:0] src_value;

  assign src_read   = reg_rd_in && (reg_addr_in == MFD_SRC_ADDR);
  assign read_clear = src_read && event_latch_enable_reg;
  // A read in the same cycle as a step lets the step update the flags.
  assign freeze     = event_active_reg && event_latch_enable_reg && !src_read;

  // Low noise caps the compare level at 4 g; each count is 0.063 g.
  assign ths_eff = (low_noise_in &&
                    threshold_value_reg > MFD_LOW_NOISE_THS_MAX)
                   ? MFD_LOW_NOISE_THS_MAX : threshold_value_reg;

  mfd_step_gen #(
    .BASE_CYCLES (STEP_CYCLES)
  ) u_step (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .odr_in     (odr_in),
    .os_mode_in (os_mode_in),
    .tick_out   (tick)
  );

  // Axes are indexed X, Y, Z from bit 0 upward.
  logic [DATA_W-1:0] accel [3];
  assign accel[0] = accel_x_in;
  assign accel[1] = accel_y_in;
  assign accel[2] = accel_z_in;

  for (genvar i = 0; i < 3; i++) begin : g_axis
    mfd_axis #(
      .DATA_W (DATA_W)
    ) u_axis (
      .ref_clk_in   (ref_clk_in),
      .rst_in       (rst_in),
      .tick_in      (tick),
      .accel_in     (accel[i]),
      .threshold_in (ths_eff),
      .enable_in    (axis_enable_reg[i]),
      .freeze_in    (freeze),
      .clear_in     (read_clear),
      .high_out     (high[i]),
      .low_out      (low[i]),
      .flag_out     (flag[i]),
      .pol_out      (pol[i])
    );
  end

  // Freefall is an AND over enabled axes, motion an OR.
  assign any_en = |axis_enable_reg;
  always_comb begin
    if (axis_combine_select_reg) begin
      condition = |(high & axis_enable_reg);
    end else begin
      condition = any_en && &(low | ~axis_enable_reg);
    end
  end

  // Configuration register writes.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      {event_latch_enable_reg, axis_combine_select_reg,
       axis_enable_reg} <= MFD_CFG_RESET;
    end else if (reg_wr_in && reg_addr_in == MFD_CFG_ADDR) begin
      event_latch_enable_reg  <= reg_wdata_in[MFD_CFG_LATCH_BIT];
      axis_combine_select_reg <= reg_wdata_in[MFD_CFG_COMBINE_BIT];
      axis_enable_reg         <= {reg_wdata_in[MFD_CFG_ZEN_BIT],
                                  reg_wdata_in[MFD_CFG_YEN_BIT],
                                  reg_wdata_in[MFD_CFG_XEN_BIT]};
    end
  end

  // Threshold register writes.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      debounce_mode_select_reg <= MFD_MODE_RESET;
      threshold_value_reg      <= MFD_THS_RESET;
    end else if (reg_wr_in && reg_addr_in == MFD_THS_ADDR) begin
      debounce_mode_select_reg <= reg_wdata_in[MFD_THS_MODE_BIT];
      threshold_value_reg      <= reg_wdata_in[MFD_THS_MSB:0];
    end
  end

  // Debounce count register writes.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      motion_debounce_count_reg <= MFD_COUNT_RESET;
    end else if (reg_wr_in && reg_addr_in == MFD_COUNT_ADDR) begin
      motion_debounce_count_reg <= reg_wdata_in;
    end
  end

  // Debounce counter and event-active next values.
  always_comb begin
    cnt_base          = read_clear ? 8'h00 : debounce_cnt_reg;
    ea_base           = read_clear ? 1'b0 : event_active_reg;
    debounce_cnt_next = cnt_base;
    event_active_next = ea_base;
    if (!any_en) begin
      debounce_cnt_next = 8'h00;
      event_active_next = 1'b0;
    end else if (tick) begin
      if (condition) begin
        // Lowering the count below the counter pulls it back to the count.
        if (cnt_base < motion_debounce_count_reg) begin
          debounce_cnt_next = cnt_base + 8'h01;
        end else begin
          debounce_cnt_next = motion_debounce_count_reg;
        end
      end else if (debounce_mode_select_reg) begin
        debounce_cnt_next = 8'h00;
      end else if (cnt_base != 8'h00) begin
        debounce_cnt_next = cnt_base - 8'h01;
      end
      if (event_latch_enable_reg && ea_base) begin
        event_active_next = 1'b1;
      end else if (condition &&
                   debounce_cnt_next == motion_debounce_count_reg) begin
        event_active_next = 1'b1;
      end else if (debounce_cnt_next == 8'h00) begin
        // Decrement mode holds the event until the counter drains.
        event_active_next = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      debounce_cnt_reg <= 8'h00;
    end else begin
      debounce_cnt_reg <= debounce_cnt_next;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      event_active_reg <= 1'b0;
    end else begin
      event_active_reg <= event_active_next;
    end
  end

  // Interrupt outputs; the route bit picks pin 1 when set.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      int1_out         <= 1'b0;
      int2_out         <= 1'b0;
      event_active_out <= 1'b0;
    end else begin
      int1_out <= event_active_next && motion_irq_enable_in &&
                  motion_irq_pin_route_in;
      int2_out <= event_active_next && motion_irq_enable_in &&
                  !motion_irq_pin_route_in;
      event_active_out <= event_active_next;
    end
  end

  always_comb begin
    src_value                   = 8'h00;
    src_value[MFD_SRC_EA_BIT]   = event_active_reg;
    src_value[MFD_SRC_ZFLG_BIT] = flag[2];
    src_value[MFD_SRC_ZPOL_BIT] = pol[2];
    src_value[MFD_SRC_YFLG_BIT] = flag[1];
    src_value[MFD_SRC_YPOL_BIT] = pol[1];
    src_value[MFD_SRC_XFLG_BIT] = flag[0];
    src_value[MFD_SRC_XPOL_BIT] = pol[0];
  end

  // Read data is registered; it holds until the next read.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        MFD_CFG_ADDR: begin
          reg_rdata_out <= {event_latch_enable_reg, axis_combine_select_reg,
                            axis_enable_reg, 3'h0};
        end
        MFD_SRC_ADDR: begin
          reg_rdata_out <= src_value;
        end
        MFD_THS_ADDR: begin
          reg_rdata_out <= {debounce_mode_select_reg, threshold_value_reg};
        end
        MFD_COUNT_ADDR: begin
          reg_rdata_out <= motion_debounce_count_reg;
        end
        default: begin
          reg_rdata_out <= 8'h00;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== bench/mfd_core_monitor.sv ====
// Port-level assertions for the freefall/motion debounce core.
`timescale 1ns/1ns
`default_nettype none
module mfd_core_monitor
  import mfd_pkg::*;
(
  input wire logic       ref_clk_in,
  input wire logic       rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       motion_irq_enable_in,
  input wire logic       motion_irq_pin_route_in,
  input wire logic       int1_out,
  input wire logic       int2_out,
  input wire logic       event_active_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_rd(a);
    reg_rd_in && (reg_addr_in == a);
  endsequence

  sequence s_wr_rd(a);
    (reg_wr_in && (reg_addr_in == a)) ##1 s_rd(a);
  endsequence

  // Interrupt levels use the gate inputs seen at the same edge as EA.
  AST_INT1_GATE: assert property (int1_out == (event_active_out &&
    $past(motion_irq_enable_in) && $past(motion_irq_pin_route_in)))
    else $error("int1 does not follow gated event active");
  AST_INT2_GATE: assert property (int2_out == (event_active_out &&
    $past(motion_irq_enable_in) && !$past(motion_irq_pin_route_in)))
    else $error("int2 does not follow gated event active");
  AST_RDATA_HOLD: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  AST_CFG_ZERO: assert property (s_rd(MFD_CFG_ADDR) |=>
    reg_rdata_out[2:0] == 3'h0)
    else $error("config low bits not zero");
  AST_SRC_EA: assert property (s_rd(MFD_SRC_ADDR) |=>
    (reg_rdata_out[7] == $past(event_active_out)) && !reg_rdata_out[6])
    else $error("source event bit differs from event active");
  AST_THS_WR_RD: assert property (s_wr_rd(MFD_THS_ADDR) |=>
    reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("threshold readback wrong");
  AST_CNT_WR_RD: assert property (s_wr_rd(MFD_COUNT_ADDR) |=>
    reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("debounce count readback wrong");
  AST_UNMAPPED: assert property (reg_rd_in && (reg_addr_in < MFD_CFG_ADDR ||
    reg_addr_in > MFD_COUNT_ADDR) |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind mfd_core mfd_core_monitor u_mfd_core_monitor (
  .ref_clk_in, .rst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
  .reg_wdata_in, .reg_rdata_out, .motion_irq_enable_in,
  .motion_irq_pin_route_in, .int1_out, .int2_out, .event_active_out);
`default_nettype wire

// ==== bench/mfd_core_test.sv ====
// Self-checking bench for the freefall/motion debounce core.
`timescale 1ns/1ns
`default_nettype none
module mfd_core_test;
  import mfd_pkg::*;
  localparam int S = 4;
  logic       ref_clk_in, rst_in, wr, rd, ln, ien, rte, i1, i2, ea;
  logic [7:0] addr, wdata, rdata, ax, ay, az, cfg_m, ths_m, cnt_m, msk, e;
  logic [2:0] odr;
  logic [1:0] osm;
  int         err_total, n_tests, cyc, seed, r, q;

  mfd_core #(.STEP_CYCLES(S)) u_mfd_core (
    .ref_clk_in, .rst_in, .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .accel_x_in(ax), .accel_y_in(ay), .accel_z_in(az),
    .odr_in(odr), .os_mode_in(osm), .low_noise_in(ln),
    .motion_irq_enable_in(ien), .motion_irq_pin_route_in(rte),
    .int1_out(i1), .int2_out(i2), .event_active_out(ea));

  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 10000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [7:0] s, x);
    n_tests++;
    if (s !== x) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask

  function automatic logic [7:0] mdl(input logic [7:0] a);
    case (a)
      MFD_CFG_ADDR:   return cfg_m;
      MFD_THS_ADDR:   return ths_m;
      MFD_COUNT_ADDR: return cnt_m;
      default:        return 8'h00;
    endcase
  endfunction

  // Polarity of an enabled axis below threshold is masked, because it keeps
  // the sign of the last event rather than reading zero.
  function automatic logic [7:0] src_exp();
    logic [7:0] v [3];
    logic       any, all;
    int         a, t;
    v[0] = ax;
    v[1] = ay;
    v[2] = az;
    src_exp = 8'h00;
    msk = 8'hBF;
    any = 1'b0;
    all = (cfg_m[5:3] != 3'h0);
    t = (ln && ths_m[6:0] > 63) ? 63 : ths_m[6:0];
    for (int i = 0; i < 3; i++) begin
      a = $signed(v[i]);
      if (a < 0) a = -a;
      if (cfg_m[3+i] && a > t) begin
        src_exp[2*i+1] = 1'b1;
        src_exp[2*i] = v[i][7];
        any = 1'b1;
        all = 1'b0;
      end else if (cfg_m[3+i]) msk[2*i] = 1'b0;
    end
    src_exp[7] = cfg_m[6] ? any : all;
  endfunction

  task automatic rd_reg(input logic [7:0] a);
    addr = a;
    rd = 1'b1;
    @(negedge ref_clk_in);
    rd = 1'b0;
    @(negedge ref_clk_in);
  endtask

  task automatic wr_reg(input logic [7:0] a, d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    if (a == MFD_CFG_ADDR) cfg_m = d & 8'hF8;
    if (a == MFD_THS_ADDR) ths_m = d;
    if (a == MFD_COUNT_ADDR) cnt_m = d;
    @(negedge ref_clk_in);
    wr = 1'b0;
    rd_reg(a);
    chk("readback", rdata, mdl(a));
  endtask

  // Waits keep a step of slack, since the tick phase is not at the ports.
  task automatic ea_at(input int n, input logic x);
    repeat (n) @(negedge ref_clk_in);
    chk("event_active", {7'h00, ea}, {7'h00, x});
  endtask

  task automatic probe(input logic [7:0] c, t, x, y, z);
    wr_reg(MFD_CFG_ADDR, c);
    wr_reg(MFD_THS_ADDR, t);
    ax = x;
    ay = y;
    az = z;
    repeat (2 * S + 2) @(negedge ref_clk_in);
    e = src_exp();
    rd_reg(MFD_SRC_ADDR);
    chk("source", rdata & msk, e);
    chk("event_active", {7'h00, ea}, {7'h00, e[7]});
    chk("int1", {7'h00, i1}, {7'h00, e[7] & ien & rte});
    chk("int2", {7'h00, i2}, {7'h00, e[7] & ien & ~rte});
  endtask

  initial begin
    seed = 5513;
    {rst_in, wr, rd, ln, ien, rte} = 6'h20;
    odr = 3'h0;
    osm = 2'h0;
    {addr, wdata, ax, ay, az, cfg_m, ths_m, cnt_m} = 64'h0;
    repeat (3) @(negedge ref_clk_in);
    rst_in = 1'b0;
    for (int a = 8'h15; a <= 8'h18; a++) begin
      rd_reg(8'(a));
      chk("reset", rdata, 8'h00);
    end
    wr_reg(MFD_SRC_ADDR, 8'hFF);
    wr_reg(8'h20, 8'h5A);
    probe(8'h48, 8'h8A, 8'h14, 8'h00, 8'h00);
    probe(8'h48, 8'h8A, 8'hEC, 8'h00, 8'h00);
    probe(8'h48, 8'h8A, 8'h0A, 8'h64, 8'h64);
    probe(8'h38, 8'h8A, 8'h0A, 8'hF6, 8'h00);
    probe(8'h38, 8'h8A, 8'h0A, 8'hF6, 8'h0B);
    ln = 1'b1;
    probe(8'h48, 8'hE4, 8'h46, 8'h00, 8'h00);
    ln = 1'b0;
    probe(8'h48, 8'hE4, 8'h46, 8'h00, 8'h00);
    probe(8'h40, 8'h80, 8'h14, 8'h14, 8'h14);
    repeat (40) begin
      r = $random(seed);
      q = $random(seed);
      {rte, ien, ln} = q[10:8];
      probe({1'b0, q[6:3], 3'h0}, {1'b1, r[30:24]}, r[7:0], r[15:8],
            r[23:16]);
    end
    wr_reg(MFD_COUNT_ADDR, 8'h03);
    wr_reg(MFD_CFG_ADDR, 8'h48);
    wr_reg(MFD_THS_ADDR, 8'h8A);
    ax = 8'h00;
    ea_at(3 * S, 1'b0);
    ax = 8'h14;
    ea_at(2 * S, 1'b0);
    ea_at(S + 2, 1'b1);
    ax = 8'h00;
    ea_at(S + 1, 1'b0);
    ax = 8'h14;
    ea_at(2 * S, 1'b0);
    wr_reg(MFD_THS_ADDR, 8'h0A);
    ea_at(10 * S, 1'b1);
    ax = 8'h00;
    ea_at(2 * S, 1'b1);
    ea_at(S + 2, 1'b0);
    wr_reg(MFD_CFG_ADDR, 8'hC8);
    wr_reg(MFD_THS_ADDR, 8'h8A);
    ax = 8'h14;
    ea_at(4 * S, 1'b1);
    ax = 8'hEC;
    ea_at(2 * S, 1'b1);
    ax = 8'h00;
    ea_at(2 * S, 1'b1);
    rd_reg(MFD_SRC_ADDR);
    chk("frozen", rdata, 8'h82);
    chk("event_active", {7'h00, ea}, 8'h00);
    rd_reg(MFD_SRC_ADDR);
    chk("cleared", rdata, 8'h00);
    ax = 8'h14;
    ea_at(2 * S, 1'b0);
    ea_at(S + 2, 1'b1);
    // At 200 Hz high resolution caps the step at twice the base step.
    wr_reg(MFD_CFG_ADDR, 8'h48);
    wr_reg(MFD_COUNT_ADDR, 8'h02);
    odr = 3'h2;
    osm = 2'h2;
    ax = 8'h00;
    ea_at(8 * S, 1'b0);
    ax = 8'h14;
    ea_at(2 * S, 1'b0);
    ea_at(2 * S + 2, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
